// *** mds_bank_store.sv ***
`default_nettype none

package mds_pkg;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned ACC_W     = 40;
  localparam int unsigned ACC_BYTES = 5;
  localparam int unsigned NPARAM    = 8;
  localparam int unsigned NBANK     = 2;
  // low address byte decode
  localparam logic [7:0] OFS_CTL    = 8'h00;
  localparam logic [7:0] OFS_PARAM0 = 8'h00;
  localparam logic [7:0] OFS_ACC0   = 8'h08;
  localparam logic [7:0] OFS_ACC4   = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h0D;
  // upper address byte marking the last transfer of a block
  localparam logic [7:0] FINAL_HI   = 8'h01;
  localparam logic [7:0] FORCE_SWAP = 8'h80;
  localparam int unsigned STAT_HOST_LSB = 0;
  localparam int unsigned STAT_EXEC_LSB = 2;
  localparam logic [7:0]  RD_ZERO       = 8'h00;
  localparam logic [3:0]  STAT_PAD      = 4'h0;

  typedef enum logic [1:0] {
    HB_EMPTY = 2'b00,
    HB_READY = 2'b01,
    HB_DONE  = 2'b11
  } mds_host_e;

  typedef enum logic [1:0] {
    EB_EMPTY = 2'b00,
    EB_BUSY  = 2'b10,
    EB_DONE  = 2'b11
  } mds_exec_e;

  // accumulator byte decode, used by read and write paths
  function automatic logic mds_is_acc(input logic [7:0] ofs);
    mds_is_acc = (ofs >= OFS_ACC0) && (ofs <= OFS_ACC4);
  endfunction : mds_is_acc
endpackage : mds_pkg

// two banks of parameters and accumulators, selected by host_sel
module mds_bank_store
  import mds_pkg::*;
#(
  parameter int unsigned PW = DATA_W
) (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic                  host_sel,
  input  wire logic                  par_we,
  input  wire logic [2:0]            par_idx,
  input  wire logic [PW-1:0]         wdata,
  input  wire logic                  acc_we,
  input  wire logic [2:0]            acc_idx,
  input  wire logic                  acc_clr,
  input  wire logic                  exec_acc_we,
  input  wire logic [ACC_W-1:0]      exec_acc_d,
  output logic      [NPARAM*PW-1:0]  host_par,
  output logic      [ACC_W-1:0]      host_acc,
  output logic      [NPARAM*PW-1:0]  exec_par,
  output logic      [ACC_W-1:0]      exec_acc
);
  logic [NPARAM*PW-1:0] par_q [NBANK];
  logic [ACC_W-1:0]     acc_q [NBANK];

  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      // each bank keeps its own parameter set and accumulator
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          par_q[b] <= '0;
        end else if (par_we && (host_sel == 1'(b))) begin
          par_q[b][par_idx*PW +: PW] <= wdata;
        end
      end

      // host side loads bytes, execution side writes whole sums
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          acc_q[b] <= '0;
        end else if (host_sel == 1'(b)) begin
          if (acc_clr) begin
            acc_q[b] <= '0;
          end else if (acc_we) begin
            acc_q[b][acc_idx*8 +: 8] <= wdata[7:0];
          end
        end else if (exec_acc_we) begin
          acc_q[b] <= exec_acc_d;
        end
      end
    end
  endgenerate

  // bank views
  assign host_par = par_q[host_sel];
  assign host_acc = acc_q[host_sel];
  assign exec_par = par_q[~host_sel];
  assign exec_acc = acc_q[~host_sel];
endmodule : mds_bank_store

`default_nettype wire

// *** mds_cpu_model.sv ***
`default_nettype none

// processor side of the i/o bus, one transfer per task call
module mds_cpu_model
  import mds_pkg::*;
(
  input  wire logic              core_clk,
  output logic      [ADDR_W-1:0] io_addr,
  output logic      [DATA_W-1:0] io_wdata,
  output logic                   io_wr,
  output logic                   io_rd,
  input  wire logic [DATA_W-1:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet bus at time zero
  initial begin
    io_addr  = '0;
    io_wdata = '0;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
  end

  // released strobes go low; address and data lines show the inverse of their last value
  task automatic release_bus();
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = ~io_addr;
    io_wdata = ~io_wdata;
  endtask : release_bus

  // hi is 01h only on the last transfer of a block; 80h to status only when forcing
  task automatic io_write(input logic [7:0] hi, input logic [7:0] ofs, input logic [7:0] d);
    @(negedge core_clk);
    io_addr  = {hi, ofs};
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge core_clk);
    release_bus();
  endtask : io_write

  // read data is taken one cycle after the strobe edge
  task automatic io_read(input logic [7:0] hi, input logic [7:0] ofs, output logic [7:0] d);
    @(negedge core_clk);
    io_addr = {hi, ofs};
    io_rd   = 1'b1;
    @(negedge core_clk);
    d = io_rdata;
    release_bus();
  endtask : io_read
endmodule : mds_cpu_model

`default_nettype wire

// *** mds_sequencer.sv ***
`default_nettype none

module mds_sequencer
  import mds_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  input  wire logic [ADDR_W-1:0]        io_addr,
  input  wire logic [DATA_W-1:0]        io_wdata,
  input  wire logic                     io_wr,
  input  wire logic                     io_rd,
  output logic      [DATA_W-1:0]        io_rdata,
  output logic                          execution_bank_start,
  input  wire logic                     execution_bank_done,
  input  wire logic                     acc_upd_valid,
  input  wire logic [ACC_W-1:0]         acc_upd_value,
  output logic      [NPARAM*DATA_W-1:0] exec_params,
  output logic      [ACC_W-1:0]         exec_acc
);
  mds_host_e host_q;
  mds_host_e host_d;
  mds_exec_e exec_q;
  mds_exec_e exec_d;
  logic      host_sel_q;
  logic      swap;
  logic      start_q;
  logic [7:0]  lo;
  logic        fin;
  logic        wr_acc;
  logic        wr_ctl_fin;
  logic        define;
  logic        force_sw;
  logic        release_done;
  logic        done_evt;
  logic [NPARAM*DATA_W-1:0] host_par;
  logic [ACC_W-1:0]         host_acc;

  // address decode
  assign lo         = io_addr[7:0];
  assign fin        = (io_addr[15:8] == FINAL_HI);
  assign wr_acc     = io_wr && mds_is_acc(lo);
  assign wr_ctl_fin = io_wr && (lo == OFS_CTL) && fin;
  assign define     = wr_ctl_fin || (wr_acc && fin) || (io_wr && lo == OFS_ACC4);
  assign force_sw   = io_wr && (lo == OFS_STAT) && (io_wdata == FORCE_SWAP);
  assign done_evt   = (exec_q == EB_BUSY) && execution_bank_done;
  // result release from a finished host bank
  assign release_done = (io_rd && lo == OFS_ACC4) ||
                        (io_rd && mds_is_acc(lo) && fin) ||
                        (io_wr && lo != OFS_STAT &&
                         (mds_is_acc(lo) || lo < OFS_ACC0));

  // next bank states and swap decision
  always_comb begin
    host_d = host_q;
    exec_d = exec_q;
    swap   = 1'b0;
    case (host_q)
      HB_EMPTY: begin
        case (exec_q)
          EB_EMPTY: begin
            if (define) begin
              swap   = 1'b1;
              exec_d = EB_BUSY;
            end
          end
          EB_BUSY: begin
            if (define && done_evt) begin
              swap   = 1'b1;
              host_d = HB_DONE;
            end else if (define) begin
              host_d = HB_READY;
            end else if (done_evt) begin
              exec_d = EB_DONE;
            end
          end
          EB_DONE: begin
            if (define) begin
              swap   = 1'b1;
              host_d = HB_DONE;
              exec_d = EB_BUSY;
            end else if (force_sw) begin
              swap   = 1'b1;
              host_d = HB_DONE;
              exec_d = EB_EMPTY;
            end
          end
          default: exec_d = EB_EMPTY;
        endcase
      end
      HB_READY: begin
        if (done_evt) begin
          swap   = 1'b1;
          host_d = HB_DONE;
        end
      end
      HB_DONE: begin
        if (release_done) begin
          host_d = HB_EMPTY;
        end
        if (done_evt) begin
          exec_d = EB_DONE;
        end
      end
      default: host_d = HB_EMPTY;
    endcase
  end

  // bank state registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_q <= HB_EMPTY;
      exec_q <= EB_EMPTY;
    end else begin
      host_q <= host_d;
      exec_q <= exec_d;
    end
  end

  // bank role selector, flipped on every swap
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_sel_q <= 1'b0;
    end else if (swap) begin
      host_sel_q <= ~host_sel_q;
    end
  end

  // start pulse whenever a swap hands a calculation to execution
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= swap && (exec_d == EB_BUSY);
    end
  end
  assign execution_bank_start = start_q;

  // storage for both banks
  mds_bank_store #(
    .PW (DATA_W)
  ) u_store (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .host_sel    (host_sel_q),
    .par_we      (io_wr && lo < OFS_ACC0),
    .par_idx     (lo[2:0]),
    .wdata       (io_wdata),
    .acc_we      (wr_acc),
    .acc_idx     (3'(lo - OFS_ACC0)),
    .acc_clr     (wr_ctl_fin),
    .exec_acc_we (acc_upd_valid && exec_q == EB_BUSY),
    .exec_acc_d  (acc_upd_value),
    .host_par    (host_par),
    .host_acc    (host_acc),
    .exec_par    (exec_params),
    .exec_acc    (exec_acc)
  );

  // read data, registered; only the host bank is visible
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata <= RD_ZERO;
    end else if (io_rd) begin
      if (lo == OFS_STAT) begin
        io_rdata <= {STAT_PAD, exec_q, host_q};
      end else if (mds_is_acc(lo)) begin
        io_rdata <= host_acc[3'(lo - OFS_ACC0)*8 +: 8];
      end else if (lo < OFS_ACC0) begin
        io_rdata <= host_par[lo[2:0]*DATA_W +: DATA_W];
      end else begin
        io_rdata <= RD_ZERO;
      end
    end
  end

  // checks
  property p_no_invalid;
    @(posedge core_clk) disable iff (!arst_n)
      (host_q != 2'b10) && (exec_q != 2'b01);
  endproperty
  a_no_invalid: assert property (p_no_invalid) else $error("invalid bank code");

  property p_stat_read_quiet;
    @(posedge core_clk) disable iff (!arst_n)
      (io_rd && !io_wr && lo == OFS_STAT && !execution_bank_done) |=> $stable(host_q) && $stable(exec_q);
  endproperty
  a_stat_read_quiet: assert property (p_stat_read_quiet)
    else $error("status read changed state");

  property p_both_empty_swap;
    @(posedge core_clk) disable iff (!arst_n)
      (host_q == HB_EMPTY && exec_q == EB_EMPTY && define)
        |=> (exec_q == EB_BUSY && host_q == HB_EMPTY && execution_bank_start &&
             host_sel_q != $past(host_sel_q));
  endproperty
  a_both_empty_swap: assert property (p_both_empty_swap)
    else $error("no swap from empty");

  property p_ready_on_define;
    @(posedge core_clk) disable iff (!arst_n)
      (host_q == HB_EMPTY && exec_q == EB_BUSY && define && !execution_bank_done)
        |=> (host_q == HB_READY && $stable(host_sel_q));
  endproperty
  a_ready_on_define: assert property (p_ready_on_define) else $error("host not ready");

  property p_finish_no_swap;
    @(posedge core_clk) disable iff (!arst_n)
      (host_q == HB_EMPTY && exec_q == EB_BUSY && execution_bank_done && !define)
        |=> (exec_q == EB_DONE && $stable(host_sel_q));
  endproperty
  a_finish_no_swap: assert property (p_finish_no_swap) else $error("finish mishandled");

  property p_force_swap;
    @(posedge core_clk) disable iff (!arst_n)
      (host_q == HB_EMPTY && exec_q == EB_DONE && force_sw && !define)
        |=> (host_q == HB_DONE && exec_q == EB_EMPTY && host_sel_q != $past(host_sel_q));
  endproperty
  a_force_swap: assert property (p_force_swap) else $error("forced swap failed");

  property p_ready_swap;
    @(posedge core_clk) disable iff (!arst_n)
      (host_q == HB_READY && execution_bank_done)
        |=> (host_q == HB_DONE && exec_q == EB_BUSY && execution_bank_start) ##1 !execution_bank_start;
  endproperty
  a_ready_swap: assert property (p_ready_swap) else $error("ready swap failed");

  property p_release;
    @(posedge core_clk) disable iff (!arst_n)
      (host_q == HB_DONE && io_rd && lo == OFS_ACC4) |=> (host_q == HB_EMPTY);
  endproperty
  a_release: assert property (p_release) else $error("result not released");

  property p_define_after_done;
    @(posedge core_clk) disable iff (!arst_n)
      (host_q == HB_EMPTY && exec_q == EB_DONE && define)
        |=> (host_q == HB_DONE && exec_q == EB_BUSY);
  endproperty
  a_define_after_done: assert property (p_define_after_done)
    else $error("define swap failed");

  property p_stat_layout;
    @(posedge core_clk) disable iff (!arst_n)
      (io_rd && lo == OFS_STAT) |=> (io_rdata == {STAT_PAD, $past(exec_q), $past(host_q)});
  endproperty
  a_stat_layout: assert property (p_stat_layout) else $error("status layout wrong");

  property p_acc_read_host;
    @(posedge core_clk) disable iff (!arst_n)
      (io_rd && lo == OFS_ACC4) |=> (io_rdata == $past(host_acc[ACC_W-1 -: DATA_W]));
  endproperty
  a_acc_read_host: assert property (p_acc_read_host) else $error("wrong bank read");

  property p_release_final;
    @(posedge core_clk) disable iff (!arst_n)
      (host_q == HB_DONE && io_rd && fin && mds_is_acc(lo)) |=> (host_q == HB_EMPTY);
  endproperty
  a_release_final: assert property (p_release_final) else $error("final read kept");

  property p_release_write;
    @(posedge core_clk) disable iff (!arst_n)
      (host_q == HB_DONE && io_wr && lo < OFS_ACC0) |=> (host_q == HB_EMPTY);
  endproperty
  a_release_write: assert property (p_release_write) else $error("write kept result");

  property p_stat_write_keep;
    @(posedge core_clk) disable iff (!arst_n)
      (io_wr && lo == OFS_STAT && io_wdata != FORCE_SWAP && !execution_bank_done)
        |=> $stable(host_q) && $stable(exec_q) && $stable(host_sel_q);
  endproperty
  a_stat_write_keep: assert property (p_stat_write_keep)
    else $error("status write acted");

  property p_ctl_clear;
    @(posedge core_clk) disable iff (!arst_n)
      (wr_ctl_fin && exec_q == EB_BUSY && !execution_bank_done) |=> (host_acc == '0);
  endproperty
  a_ctl_clear: assert property (p_ctl_clear) else $error("accumulator not cleared");

  property p_exec_update;
    @(posedge core_clk) disable iff (!arst_n)
      (acc_upd_valid && exec_q == EB_BUSY && !execution_bank_done)
        |=> (exec_acc == $past(acc_upd_value));
  endproperty
  a_exec_update: assert property (p_exec_update) else $error("sum not stored");
endmodule : mds_sequencer

`default_nettype wire

// *** mds_tb.sv ***
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mds_pkg::*;

  logic                     core_clk      = 1'b0;
  logic                     arst_n        = 1'b0;
  logic                     execution_bank_done     = 1'b0;
  logic                     acc_upd_valid = 1'b0;
  logic [ACC_W-1:0]         acc_upd_value = '0;
  logic [ADDR_W-1:0]        io_addr;
  logic [DATA_W-1:0]        io_wdata;
  logic                     io_wr;
  logic                     io_rd;
  logic [DATA_W-1:0]        io_rdata;
  logic                     execution_bank_start;
  logic [NPARAM*DATA_W-1:0] exec_params;
  logic [ACC_W-1:0]         exec_acc;
  logic [7:0]               starts        = '0;
  int                       fails         = 0;
  int                       num_checks    = 0;

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  // count handovers to the execution bank
  always @(posedge core_clk) if (execution_bank_start === 1'b1) starts <= starts + 8'h01;

  mds_sequencer i_mds_sequencer (
    .core_clk(core_clk), .arst_n(arst_n), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .execution_bank_start(execution_bank_start),
    .execution_bank_done(execution_bank_done), .acc_upd_valid(acc_upd_valid), .acc_upd_value(acc_upd_value),
    .exec_params(exec_params), .exec_acc(exec_acc)
  );

  mds_cpu_model i_mds_cpu_model (
    .core_clk(core_clk), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata)
  );

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk64

  task automatic wr(input logic [7:0] hi, input logic [7:0] ofs, input logic [7:0] d);
    i_mds_cpu_model.io_write(hi, ofs, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] hi, input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    i_mds_cpu_model.io_read(hi, ofs, d);
    chk8(d, exp);
  endtask : rd_chk

  // datapath finishes, optionally after a last accumulator update
  task automatic finish_execution_bank(input logic upd, input logic [ACC_W-1:0] v);
    @(negedge core_clk);
    acc_upd_valid = upd;
    acc_upd_value = v;
    @(negedge core_clk);
    acc_upd_valid = 1'b0;
    acc_upd_value = ~acc_upd_value;
    execution_bank_done     = 1'b1;
    @(negedge core_clk);
    execution_bank_done = 1'b0;
  endtask : finish_execution_bank

  task automatic t_first();
    rd_chk(8'h00, OFS_STAT, 8'h00);
    wr(8'h00, 8'h01, 8'hA5);
    wr(8'h00, OFS_ACC4, 8'h12);
    rd_chk(8'h00, OFS_STAT, 8'h08);
    chk8(exec_params[15:8], 8'hA5);
    chk8(starts, 8'h01);
  endtask : t_first

  task automatic t_queue();
    wr(8'h00, 8'h01, 8'h5A);
    wr(8'h00, OFS_ACC0, 8'h77);
    wr(FINAL_HI, OFS_CTL, 8'h3C);
    rd_chk(8'h00, OFS_STAT, 8'h09);
    chk8(exec_params[15:8], 8'hA5);
  endtask : t_queue

  task automatic t_swap_ready();
    finish_execution_bank(1'b1, 40'h12_3456_789A);
    rd_chk(8'h00, OFS_STAT, 8'h0B);
    chk64(64'(exec_acc), 64'h0);
    chk8(exec_params[15:8], 8'h5A);
    chk8(starts, 8'h02);
    rd_chk(8'h00, OFS_ACC0, 8'h9A);
    rd_chk(8'h00, OFS_STAT, 8'h0B);
    rd_chk(8'h00, OFS_ACC4, 8'h12);
    rd_chk(8'h00, OFS_STAT, 8'h08);
  endtask : t_swap_ready

  task automatic t_force();
    finish_execution_bank(1'b0, '0);
    rd_chk(8'h00, OFS_STAT, 8'h0C);
    wr(8'h00, OFS_STAT, 8'h55);
    rd_chk(8'h00, OFS_STAT, 8'h0C);
    wr(8'h00, OFS_STAT, FORCE_SWAP);
    rd_chk(8'h00, OFS_STAT, 8'h03);
    rd_chk(8'h00, OFS_STAT, 8'h03);
    wr(8'h00, 8'h02, 8'h00);
    rd_chk(8'h00, OFS_STAT, 8'h00);
  endtask : t_force

  task automatic t_define_done();
    wr(8'h00, OFS_ACC4, 8'h01);
    finish_execution_bank(1'b0, '0);
    rd_chk(8'h00, OFS_STAT, 8'h0C);
    wr(FINAL_HI, OFS_ACC0, 8'h00);
    rd_chk(8'h00, OFS_STAT, 8'h0B);
    rd_chk(FINAL_HI, 8'h09, 8'h00);
    rd_chk(8'h00, OFS_STAT, 8'h08);
  endtask : t_define_done

  task automatic test_done();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    t_first();
    t_queue();
    t_swap_ready();
    t_force();
    t_define_done();
    test_done();
  end

  // watchdog
  initial begin
    #20000;
    fails++;
    test_done();
  end
endmodule : tb

`default_nettype wire
